// File: src/mrc_ctrl.sv
// reset, interrupt latching, priority, vectoring and sleep control for an 8-bit cpu
// Notes on behaviour
// - after oscillator start hold reset 4064 cycles, longer while reset pin low
// - reset pin low for one and a half cycles resets the device
// - seven sources; only the software trap ignores the mask
// - taking an interrupt pushes registers and sets the cpu mask bit
// - return from interrupt pops registers and resumes
// - hardware requests wait for the current instruction to finish
// - at a boundary, take a pending hardware request only when mask is clear
// - pin, wake and tick requests OR into one combined cpu request
// - priority tick, pin, wake, timer a, timer b, serial; vectors FFFA..FFF4
// - reset vectors through FFFE/FFFF and sets the mask bit
// - stop sleeps until enabled pin, enabled wake, or reset
// - wait keeps timers; exits on reset, pin, wake, timer, serial
// - trap ignores mask, after already pending requests, vector FFFC
// - mask set blocks every maskable request; clearing re-enables
// - a further pin pulse while being served merges into the still-set flag until acknowledged
// - pin request latched after selected edge, synchronised, gated by pass bit
// - tick request latched on expiry, gated by tick enable at 0018
// - wake request from any enabled port c pin, enables at 0013
// - timer a and b requests latched, gated by their pass bits
// - serial request latched per transfer, enabled by bit at 0010
// - pass bit 1 passes, 0 masks; control resets to 01
// - pin and timer flags set on request
// - writing 0 to a flag acknowledges and drops the request
// - polarity 1 rising/high, 0 falling/low, pin input only
// - trigger type 1 level, 0 edge only
`default_nettype none
module mrc_ctrl
  import mrc_pkg::*;
#(
  parameter int POR_CYCLES = MRC_POR_CYCLES
)(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_osc_ok,
  // register port
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // event sources
  input wire logic i_ext_irq_pin,
  input wire logic [7:0] i_portc,
  input wire logic i_tick_expire,
  input wire logic i_timer_a_done,
  input wire logic i_timer_b_done,
  input wire logic i_serial_done,
  // cpu handshake
  input wire mrc_cpu_req_t i_cpu,
  output mrc_cpu_ans_t o_cpu,
  output logic o_cpu_mask,
  output logic o_combined_cpu_request,
  output logic o_osc_run,
  output logic o_cpu_clk_run
);
  typedef enum logic [1:0] {MRC_RUN, MRC_STOP, MRC_WAIT} mrc_sleep_t;

  logic [12:0] por_cnt;
  logic por_done;
  logic [7:0] ictl;
  logic [7:0] tctl;
  logic serial_ie, serial_flag;
  logic tick_ie, tick_flag;
  logic [7:0] wake_en;
  logic ext_s1, ext_s2, ext_d;
  logic [7:0] pc_s1, pc_s2, pc_d;
  logic cpu_mask;
  logic trap_pend_hw;
  mrc_sleep_t sleep;
  logic ext_edge, ext_active, wake_hit;
  logic req_ext, req_tick, req_wake, req_ta, req_tb, req_ser, any_req;
  logic [15:0] sel_vec;
  logic take_hw, take_trap;

  // power-on hold: count from oscillator start, then wait for pin release
  always_ff @(posedge i_clk)
  begin
    if (!i_osc_ok)
      por_cnt <= '0;
    else if (!por_done)
      por_cnt <= por_cnt + 13'd1;
  end
  assign por_done = (por_cnt >= 13'(POR_CYCLES));
  // the pin is sampled each clock, so 1.5 cycles always covers an edge
  assign o_cpu.in_reset = !por_done || !i_rstn;

  // two-stage synchronisers on pin inputs
  always_ff @(posedge i_clk)
  begin
    ext_s1 <= i_ext_irq_pin;
    ext_s2 <= ext_s1;
    ext_d <= ext_s2;
    pc_s1 <= i_portc;
    pc_s2 <= pc_s1;
    pc_d <= pc_s2;
  end

  // polarity and trigger type only shape the pin input
  assign ext_active = ictl[MRC_B_EXT_POL] ? ext_s2 : !ext_s2;
  assign ext_edge = ictl[MRC_B_EXT_POL] ? (ext_s2 && !ext_d) : (!ext_s2 && ext_d);
  assign wake_hit = |(wake_en & pc_d & ~pc_s2); // falling pin on enabled line

  // register writes and flag latching; a set in the clearing cycle wins
  always_ff @(posedge i_clk)
  begin
    if (o_cpu.in_reset)
    begin
      ictl <= MRC_ICTL_RST;
      tctl <= MRC_TCTL_RST;
      serial_ie <= 1'b0;
      serial_flag <= 1'b0;
      tick_ie <= 1'b0;
      tick_flag <= 1'b0;
      wake_en <= 8'h00;
    end
    else
    begin
      if (i_wr && i_addr == MRC_OFF_ICTL)
      begin
        ictl[MRC_B_TB_PASS:MRC_B_EXT_PASS] <= i_wdata[MRC_B_TB_PASS:MRC_B_EXT_PASS];
        ictl[MRC_B_EXT_POL] <= i_wdata[MRC_B_EXT_POL];
        // flags are clear-only from software
        ictl[MRC_B_EXT_FLAG] <= ictl[MRC_B_EXT_FLAG] & i_wdata[MRC_B_EXT_FLAG];
        ictl[MRC_B_TA_FLAG] <= ictl[MRC_B_TA_FLAG] & i_wdata[MRC_B_TA_FLAG];
        ictl[MRC_B_TB_FLAG] <= ictl[MRC_B_TB_FLAG] & i_wdata[MRC_B_TB_FLAG];
        ictl[MRC_B_WAKE_FLAG] <= ictl[MRC_B_WAKE_FLAG] & i_wdata[MRC_B_WAKE_FLAG];
      end
      if (i_wr && i_addr == MRC_OFF_TCTL)
        tctl <= i_wdata;
      if (i_wr && i_addr == MRC_OFF_MODE)
      begin
        serial_ie <= i_wdata[MRC_B_SER_IE];
        serial_flag <= serial_flag & i_wdata[MRC_B_SER_FLAG];
      end
      if (i_wr && i_addr == MRC_OFF_TICK_CTL)
      begin
        tick_ie <= i_wdata[MRC_B_TICK_IE];
        tick_flag <= tick_flag & i_wdata[MRC_B_TICK_FLAG];
      end
      if (i_wr && i_addr == MRC_OFF_WAKE_EN)
        wake_en <= i_wdata;
      // latched pin flag stays set while served, so a further pulse merges into it
      if (tctl[MRC_B_TRIG_TYPE] ? ext_active : ext_edge)
        ictl[MRC_B_EXT_FLAG] <= 1'b1;
      if (i_timer_a_done && sleep != MRC_STOP)
        ictl[MRC_B_TA_FLAG] <= 1'b1;
      if (i_timer_b_done && sleep != MRC_STOP)
        ictl[MRC_B_TB_FLAG] <= 1'b1;
      if (wake_hit)
        ictl[MRC_B_WAKE_FLAG] <= 1'b1;
      if (i_serial_done)
        serial_flag <= 1'b1;
      // stop clears tick flag and enable
      if (sleep == MRC_STOP)
      begin
        tick_flag <= 1'b0;
        tick_ie <= 1'b0;
      end
      else if (i_tick_expire)
        tick_flag <= 1'b1;
    end
  end

  // gated requests
  assign req_tick = tick_flag && tick_ie;
  assign req_ext = ictl[MRC_B_EXT_FLAG] && ictl[MRC_B_EXT_PASS];
  assign req_wake = ictl[MRC_B_WAKE_FLAG];
  assign req_ta = ictl[MRC_B_TA_FLAG] && ictl[MRC_B_TA_PASS];
  assign req_tb = ictl[MRC_B_TB_FLAG] && ictl[MRC_B_TB_PASS];
  assign req_ser = serial_flag && serial_ie;
  assign o_combined_cpu_request = req_tick || req_ext || req_wake;
  assign any_req = o_combined_cpu_request || req_ta || req_tb || req_ser;

  // fixed priority vector choice
  always_comb
  begin
    if (o_combined_cpu_request)
      sel_vec = MRC_VEC_GROUP;
    else if (req_ta)
      sel_vec = MRC_VEC_TA;
    else if (req_tb)
      sel_vec = MRC_VEC_TB;
    else
      sel_vec = MRC_VEC_SER;
  end

  // only sampled at boundaries, so a running instruction is never cut
  assign take_hw = i_cpu.boundary && !cpu_mask && any_req && sleep == MRC_RUN;
  // pending hardware first, trap after
  assign take_trap = i_cpu.boundary && trap_pend_hw && !take_hw && sleep == MRC_RUN;

  // trap request held until served behind pending hardware requests
  always_ff @(posedge i_clk)
  begin
    if (o_cpu.in_reset)
      trap_pend_hw <= 1'b0;
    else if (take_trap)
      trap_pend_hw <= 1'b0;
    else if (i_cpu.trap)
      trap_pend_hw <= 1'b1;
  end

  // cpu mask bit
  always_ff @(posedge i_clk)
  begin
    if (o_cpu.in_reset)
      cpu_mask <= 1'b1;
    else if (take_hw || take_trap)
      cpu_mask <= 1'b1;
    else if (sleep != MRC_RUN)
      cpu_mask <= 1'b0; // sleep modes clear the mask
    else if (i_cpu.return_from_irq)
      cpu_mask <= 1'b0;
    else if (i_wr && i_addr == MRC_OFF_CPU_CTL)
      cpu_mask <= i_wdata[0];
  end

  // sleep state
  always_ff @(posedge i_clk)
  begin
    if (o_cpu.in_reset)
      sleep <= MRC_RUN;
    else
    begin
      unique case (sleep)
        MRC_RUN:
          if (i_cpu.stop)
            sleep <= MRC_STOP;
          else if (i_cpu.wait_i)
            sleep <= MRC_WAIT;
        MRC_STOP:
          if (req_ext || (req_wake && |wake_en))
            sleep <= MRC_RUN;
        MRC_WAIT:
          if (any_req)
            sleep <= MRC_RUN;
        default:
          sleep <= MRC_RUN;
      endcase
    end
  end
  assign o_osc_run = sleep != MRC_STOP;
  assign o_cpu_clk_run = sleep == MRC_RUN;

  // answer to cpu
  assign o_cpu.take = take_hw || take_trap;
  assign o_cpu.push = take_hw || take_trap;
  assign o_cpu.pop = i_cpu.return_from_irq && sleep == MRC_RUN;
  assign o_cpu.vector = o_cpu.in_reset ? MRC_VEC_RESET : (take_hw ? sel_vec : MRC_VEC_TRAP);
  assign o_cpu_mask = cpu_mask;

  // read data one cycle after the strobe
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
      o_rdata <= 8'h00;
    else if (i_rd)
    begin
      unique case (i_addr)
        MRC_OFF_ICTL: o_rdata <= ictl;
        MRC_OFF_TCTL: o_rdata <= tctl;
        MRC_OFF_MODE: o_rdata <= {serial_ie, 6'h00, serial_flag};
        MRC_OFF_WAKE_EN: o_rdata <= wake_en;
        MRC_OFF_TICK_CTL: o_rdata <= {tick_flag, 2'h0, tick_ie, 4'h0};
        MRC_OFF_CPU_CTL: o_rdata <= {6'h00, sleep != MRC_RUN, cpu_mask};
        default: o_rdata <= 8'h00;
      endcase
    end
    else
      o_rdata <= 8'h00;
  end

  // checks
  reset_mask_a: assert property (@(posedge i_clk) o_cpu.in_reset |=> cpu_mask)
    else $error("mask not set after reset");
  take_mask_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (take_hw && !o_cpu.in_reset) |=> cpu_mask)
    else $error("mask not set on take");
  masked_hold_a: assert property (@(posedge i_clk) disable iff (!i_rstn) cpu_mask |-> !take_hw)
    else $error("masked request taken");
  group_vec_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (take_hw && o_combined_cpu_request && !o_cpu.in_reset) |-> o_cpu.vector == 16'hFFFA)
    else $error("group vector wrong");
  ta_vec_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (take_hw && !o_combined_cpu_request && req_ta && !o_cpu.in_reset) |-> o_cpu.vector == 16'hFFF8)
    else $error("timer a vector wrong");
  // checked against the raw flag and gate registers, not the request nets
  comb_req_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    o_combined_cpu_request == ((tick_flag && tick_ie) || (ictl[MRC_B_EXT_FLAG] && ictl[MRC_B_EXT_PASS])
      || ictl[MRC_B_WAKE_FLAG]))
    else $error("combined request mismatch");
  por_hold_a: assert property (@(posedge i_clk) !por_done |-> o_cpu.in_reset)
    else $error("reset released early");
  pin_rst_a: assert property (@(posedge i_clk) !i_rstn |-> o_cpu.in_reset)
    else $error("pin reset ignored");
  // a trap may only go when no unmasked hardware request is waiting
  trap_order_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    take_trap |-> (cpu_mask || !any_req))
    else $error("trap beat hardware");
  flag_ack_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_wr && i_addr == MRC_OFF_ICTL && !i_wdata[MRC_B_TA_FLAG] && !i_timer_a_done && !o_cpu.in_reset)
      |=> !ictl[MRC_B_TA_FLAG])
    else $error("flag not cleared");
  take_c: cover property (@(posedge i_clk) take_hw);
  trap_c: cover property (@(posedge i_clk) take_trap);
  stop_c: cover property (@(posedge i_clk) sleep == MRC_STOP ##1 sleep == MRC_RUN);
endmodule
`default_nettype wire

// File: src/mrc_pkg.sv
// package for the reset and interrupt controller: offsets, fields, vectors, timing
`default_nettype none
package mrc_pkg;
  // register offsets
  localparam logic [7:0] MRC_OFF_ICTL = 8'h0E;
  localparam logic [7:0] MRC_OFF_TCTL = 8'h0C;
  localparam logic [7:0] MRC_OFF_MODE = 8'h10;
  localparam logic [7:0] MRC_OFF_WAKE_EN = 8'h13;
  localparam logic [7:0] MRC_OFF_TICK_CTL = 8'h18;
  localparam logic [7:0] MRC_OFF_CPU_CTL = 8'h1F;
  // interrupt control fields
  localparam int MRC_B_EXT_PASS = 0;
  localparam int MRC_B_TA_PASS = 1;
  localparam int MRC_B_TB_PASS = 2;
  localparam int MRC_B_EXT_FLAG = 3;
  localparam int MRC_B_TA_FLAG = 4;
  localparam int MRC_B_TB_FLAG = 5;
  localparam int MRC_B_EXT_POL = 6;
  localparam int MRC_B_WAKE_FLAG = 7;
  localparam int MRC_B_TRIG_TYPE = 5;
  localparam int MRC_B_SER_IE = 7;
  localparam int MRC_B_TICK_IE = 4;
  localparam int MRC_B_TICK_FLAG = 7;
  localparam int MRC_B_SER_FLAG = 0;
  localparam logic [7:0] MRC_ICTL_RST = 8'h01;
  localparam logic [7:0] MRC_TCTL_RST = 8'h08;
  // vectors (address of high byte)
  localparam logic [15:0] MRC_VEC_RESET = 16'hFFFE;
  localparam logic [15:0] MRC_VEC_TRAP = 16'hFFFC;
  localparam logic [15:0] MRC_VEC_GROUP = 16'hFFFA;
  localparam logic [15:0] MRC_VEC_TA = 16'hFFF8;
  localparam logic [15:0] MRC_VEC_TB = 16'hFFF6;
  localparam logic [15:0] MRC_VEC_SER = 16'hFFF4;
  // power-on delay in machine cycles (one cycle per clock)
  localparam int MRC_POR_CYCLES = 4064;
  // cpu handshake carriers
  typedef struct packed {
    logic boundary;
    logic trap;
    logic return_from_irq;
    logic stop;
    logic wait_i;
  } mrc_cpu_req_t;
  typedef struct packed {
    logic in_reset;
    logic take;
    logic push;
    logic pop;
    logic [15:0] vector;
  } mrc_cpu_ans_t;
endpackage
`default_nettype wire

// File: tb/mrc_cpu_model.sv
// cpu sequencer model: instruction boundaries, trap, return and sleep requests
`default_nettype none
module mrc_cpu_model
  import mrc_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // controller side
  input wire mrc_cpu_ans_t i_ans,
  input wire logic i_run,
  output mrc_cpu_req_t o_req,
  // bench side: {trap, return, stop, wait} requests, taken count, last vector
  input wire logic [3:0] i_cmd,
  output logic [7:0] o_takes,
  output logic [15:0] o_vec
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] phase;
  logic [3:0] pend;
  logic bnd;
  // one instruction every four cycles; stopped cpu clocks freeze the sequence
  assign bnd = (phase == 2'h3) && i_run && !i_ans.in_reset;
  // requests ride on the boundary of the instruction that carries them
  assign o_req = '{boundary: bnd, trap: bnd & pend[3], return_from_irq: bnd & pend[2],
                   stop: bnd & pend[1], wait_i: bnd & pend[0]};
  // requests wait for the next boundary, vectors are fetched only on take
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      phase <= 2'h0;
      pend <= 4'h0;
      o_takes <= 8'h00;
      o_vec <= 16'h0000;
    end
    else
    begin
      if (i_run && !i_ans.in_reset)
        phase <= phase + 2'h1;
      pend <= (bnd ? 4'h0 : pend) | i_cmd;
      if (bnd && i_ans.take)
      begin
        o_takes <= o_takes + 8'h01;
        o_vec <= i_ans.vector;
      end
    end
  end
endmodule
`default_nettype wire

// File: tb/test_mcu_reset_interrupt_control.sv
// self-checking bench for the reset and interrupt controller
`default_nettype none
module test_mcu_reset_interrupt_control;
  import mrc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int POR = 20;
  typedef struct packed {logic [2:0] src; logic [15:0] vec; logic grp;} mrc_row_t;
  logic clk = 0, rstn = 0, osc = 0, wr = 0, rd = 0, pin = 1, tick = 0, ta = 0, tb = 0, ser = 0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, portc = 8'hFF, rdata, takes, d;
  logic [3:0] cmd = 4'h0;
  logic [15:0] vec;
  logic req, osc_run, clk_run, mask;
  mrc_cpu_req_t creq;
  mrc_cpu_ans_t cans;
  int err_total = 0, n_tests = 0, cyc = 0, c;
  mrc_row_t rows [6] = '{'{3'h0, MRC_VEC_GROUP, 1'b1}, '{3'h1, MRC_VEC_GROUP, 1'b1},
    '{3'h2, MRC_VEC_GROUP, 1'b1}, '{3'h3, MRC_VEC_TA, 1'b0}, '{3'h4, MRC_VEC_TB, 1'b0},
    '{3'h5, MRC_VEC_SER, 1'b0}};
  mrc_ctrl #(.POR_CYCLES(POR)) i_dut (.i_clk(clk), .i_rstn(rstn), .i_osc_ok(osc), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_ext_irq_pin(pin), .i_portc(portc),
    .i_tick_expire(tick), .i_timer_a_done(ta), .i_timer_b_done(tb), .i_serial_done(ser),
    .i_cpu(creq), .o_cpu(cans), .o_cpu_mask(mask), .o_combined_cpu_request(req),
    .o_osc_run(osc_run), .o_cpu_clk_run(clk_run));
  mrc_cpu_model i_cpu (.i_clk(clk), .i_rstn(rstn), .i_ans(cans), .i_run(clk_run), .o_req(creq),
    .i_cmd(cmd), .o_takes(takes), .o_vec(vec));
  // free-running 50 MHz clock
  initial
  begin
    forever #10 clk = ~clk;
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // a hang ends the run as a failure
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      err_total++;
      finish_test();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rreg(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic pulse_cmd(input logic [3:0] v);
    @(posedge clk);
    cmd <= v;
    @(posedge clk);
    cmd <= 4'h0;
  endtask
  // pins are idle high, so a one-cycle low is a falling edge
  task automatic fire(input logic [2:0] s);
    @(posedge clk);
    case (s)
      3'h0: tick <= 1'b1;
      3'h1: pin <= 1'b0;
      3'h2: portc <= 8'hFE;
      3'h3: ta <= 1'b1;
      3'h4: tb <= 1'b1;
      default: ser <= 1'b1;
    endcase
    @(posedge clk);
    {tick, ta, tb, ser, pin, portc} <= {4'h0, 1'b1, 8'hFF};
  endtask
  task automatic wait_take(input int lim);
    logic [7:0] t0;
    t0 = takes;
    c = 0;
    while (takes === t0 && c < lim)
    begin
      @(posedge clk);
      c++;
    end
    #1 chk(16'(takes !== t0), 16'h0001);
  endtask
  // acknowledge every flag, then return and unmask
  task automatic ack_ret();
    wreg(MRC_OFF_ICTL, 8'h07);
    wreg(MRC_OFF_TICK_CTL, 8'h10);
    wreg(MRC_OFF_MODE, 8'h80);
    pulse_cmd(4'h4);
    repeat (8) @(posedge clk);
    #1 chk(mask, 1'b0);
    wreg(MRC_OFF_CPU_CTL, 8'h00);
  endtask
  initial
  begin
    // oscillator starts one edge in, so the power-on counter begins from a known zero
    @(posedge clk);
    osc <= 1'b1;
    repeat (9) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    #1 chk(cans.in_reset, 1'b1);
    chk(cans.vector, MRC_VEC_RESET);
    chk(mask, 1'b1);
    c = 0;
    while (cans.in_reset === 1'b1 && c < 40)
    begin
      @(posedge clk);
      c++;
    end
    chk(16'(c >= POR - 10 && c <= POR - 8), 16'h0001);
    rreg(MRC_OFF_ICTL, d);
    chk(d, MRC_ICTL_RST);
    rreg(8'h05, d);
    chk(d, 8'h00);
    $display("test reset done");
    wreg(MRC_OFF_ICTL, 8'h07);
    wreg(MRC_OFF_TICK_CTL, 8'h10);
    wreg(MRC_OFF_MODE, 8'h80);
    wreg(MRC_OFF_WAKE_EN, 8'h01);
    wreg(MRC_OFF_CPU_CTL, 8'h00);
    // each source alone, unmasked
    foreach (rows[i])
    begin
      fire(rows[i].src);
      wait_take(40);
      chk(vec, rows[i].vec);
      chk(mask, 1'b1);
      chk(req, rows[i].grp);
      ack_ret();
    end
    $display("test sources done");
    // masked requests wait, then the highest wins
    wreg(MRC_OFF_CPU_CTL, 8'h01);
    fire(3'h4);
    fire(3'h3);
    fire(3'h1);
    repeat (12) @(posedge clk);
    rreg(MRC_OFF_ICTL, d);
    chk(d, 8'h3F);
    chk(req, 1'b1);
    c = takes;
    repeat (8) @(posedge clk);
    chk(takes, 8'(c));
    wreg(MRC_OFF_CPU_CTL, 8'h00);
    wait_take(20);
    chk(vec, MRC_VEC_GROUP);
    ack_ret();
    rreg(MRC_OFF_ICTL, d);
    chk(d, 8'h07);
    $display("test priority done");
    // pin pass bit at 0 keeps the pin away from the cpu
    wreg(MRC_OFF_ICTL, 8'h06);
    c = takes;
    fire(3'h1);
    repeat (16) @(posedge clk);
    chk(takes, 8'(c));
    chk(req, 1'b0);
    wreg(MRC_OFF_ICTL, 8'h07);
    $display("test pass bit done");
    // rising polarity in edge mode, then level triggering; mask keeps the cpu out
    wreg(MRC_OFF_CPU_CTL, 8'h01);
    wreg(MRC_OFF_ICTL, 8'h47);
    fire(3'h1);
    repeat (6) @(posedge clk);
    rreg(MRC_OFF_ICTL, d);
    chk(d, 8'h4F);
    wreg(MRC_OFF_TCTL, 8'h28);
    wreg(MRC_OFF_ICTL, 8'h47);
    rreg(MRC_OFF_ICTL, d);
    chk(d, 8'h4F);
    wreg(MRC_OFF_TCTL, 8'h08);
    wreg(MRC_OFF_ICTL, 8'h07);
    rreg(MRC_OFF_ICTL, d);
    chk(d, 8'h07);
    $display("test polarity done");
    // trap ignores the mask
    wreg(MRC_OFF_CPU_CTL, 8'h01);
    pulse_cmd(4'h8);
    wait_take(20);
    chk(vec, MRC_VEC_TRAP);
    ack_ret();
    $display("test trap done");
    // wait sleeps the cpu, a timer wakes it through its normal vector
    pulse_cmd(4'h1);
    repeat (10) @(posedge clk);
    #1 chk(clk_run, 1'b0);
    fire(3'h3);
    wait_take(40);
    chk(vec, MRC_VEC_TA);
    chk(clk_run, 1'b1);
    ack_ret();
    $display("test wait done");
    // stop halts the oscillator until the pin
    pulse_cmd(4'h2);
    repeat (10) @(posedge clk);
    #1 chk(osc_run, 1'b0);
    fire(3'h1);
    wait_take(100);
    chk(osc_run, 1'b1);
    chk(vec, MRC_VEC_GROUP);
    ack_ret();
    $display("test stop done");
    // a two-cycle reset pulse in mid-run
    @(posedge clk);
    rstn <= 1'b0;
    #1 chk(cans.in_reset, 1'b1);
    chk(cans.vector, MRC_VEC_RESET);
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    #1 chk(mask, 1'b1);
    rreg(MRC_OFF_ICTL, d);
    chk(d, MRC_ICTL_RST);
    $display("test mid reset done");
    finish_test();
  end
endmodule
`default_nettype wire
